// ==== design/jrx_pkg.sv ====
package jrx_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int LANES_DEF   = 2;
  localparam int WORD_W      = 32;
  localparam int OCTET_W     = 8;
  localparam int OCTETS      = WORD_W / OCTET_W;
  localparam int RCFG_ADDR_W = 10;
  localparam int RCFG_DATA_W = 32;
  // ----------------------------------------
  // Reconfiguration port sharing modes
  // ----------------------------------------
  localparam logic [1:0] SHARE_ONE  = 2'h0;
  localparam logic [1:0] SHARE_BUS  = 2'h1;
  localparam logic [1:0] SHARE_SEP  = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS       = 10;
  localparam int RCFG_WAIT_NS = 20;
  localparam int RCFG_WAIT_CY = (RCFG_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] READY_DLY = 4'h3;
  // ----------------------------------------
  // Buffer and reconfiguration handshake states
  // ----------------------------------------
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {
    JRX_HS_IDLE = 2'b00,
    JRX_HS_BUSY = 2'b01,
    JRX_HS_DONE = 2'b10
  } jrx_hs_e;
endpackage

// ==== design/jrx_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface jrx_if #(
  parameter int LANES = jrx_pkg::LANES_DEF,
  parameter int NPORT = 1
);
  // Stream
  logic [LANES*jrx_pkg::WORD_W-1:0] lane_word_out;
  logic                             lane_word_valid;
  logic                             sink_accept;
  logic                             transfer_fault_in;
  // Receive readiness and reset
  logic [LANES-1:0]                 rx_ready;
  logic [LANES-1:0]                 afe_ready;
  logic                             rx_hard_reset;
  // Reconfiguration strobes
  logic                             rcfg_clk;
  logic [NPORT-1:0]                 rcfg_reset;
  logic [NPORT-1:0]                 rcfg_write;
  logic [NPORT-1:0]                 rcfg_read;
  logic [NPORT-1:0]                 rcfg_waitrequest;
  logic [NPORT-1:0]                 rcfg_afe_reset;

  modport dev (
    output lane_word_out, lane_word_valid, rx_ready, afe_ready, rcfg_waitrequest,
    input  sink_accept, transfer_fault_in, rx_hard_reset, rcfg_clk, rcfg_reset,
    input  rcfg_write, rcfg_read, rcfg_afe_reset
  );
  modport tl (
    input  lane_word_out, lane_word_valid, rx_ready, afe_ready, rcfg_waitrequest,
    output sink_accept, transfer_fault_in, rx_hard_reset, rcfg_clk, rcfg_reset,
    output rcfg_write, rcfg_read, rcfg_afe_reset
  );
endinterface
`default_nettype wire

// ==== design/jrx_dev.sv ====
// Contract
// - Master drives write strobe high to write
// - Master drives read strobe high to read
// - Strobe width follows reconfiguration sharing mode
// - Wait-request holds master until access completes
// - One receiver-ready output per lane
// - Resets only after front-end ready asserted
// - Hard reset input is active high
// - Hard reset leaves front-end untouched
// - Output bus carries 32 bits per lane
// - First octet in top byte, big endian
// - Valid high for valid word, else low
// - Source ignores backpressure when valid
// - Transport drives single ready bit
// - Transport raises frame error on fault
// - Reconfiguration reset active high, level sensitive
`timescale 1ns/10ps
`default_nettype none
module jrx_dev #(
  parameter int         LANES = jrx_pkg::LANES_DEF,
  parameter logic [1:0] SHARE = jrx_pkg::SHARE_ONE,
  parameter int         NPORT = (SHARE == jrx_pkg::SHARE_ONE) ? 1 : LANES
) (
  // Clock and reset
  input  wire logic                            I_CLK,
  input  wire logic                            I_RST,
  // Link
  jrx_if.dev                                   LNK,
  // Octets arriving from the lane decoders, one per lane per cycle
  input  wire logic [LANES*jrx_pkg::OCTET_W-1:0] I_OCTET,
  input  wire logic                            I_OCTET_VLD,
  output logic                                 O_OCTET_RDY,
  // Status
  output logic                                 O_FAULT_STICKY,
  input  wire logic                            I_FAULT_CLR,
  output logic                                 O_DROP
);
  import jrx_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [OCTETS-1:0][LANES*OCTET_W-1:0] asm_w;
    logic [$clog2(OCTETS)-1:0]            asm_cnt;
    logic [BUF_DEPTH-1:0][LANES*WORD_W-1:0] buf_d;
    logic [1:0]                           buf_n;
    logic [LANES*WORD_W-1:0]              out_d;
    logic                                 out_v;
    logic                                 fault;
    logic                                 drop;
    logic [3:0]                           rdy_cnt;
    logic [LANES-1:0]                     afe;
    logic [NPORT-1:0]                     afe_rst_s1;
    logic [NPORT-1:0]                     afe_rst_s2;
  } jrx_dev_s;

  jrx_dev_s st_reg;
  jrx_dev_s st_next;
  logic [LANES*WORD_W-1:0] word_asm;
  logic                    word_done;
  logic [NPORT-1:0]        afe_rst_rc;

  // ----------------------------------------
  // Octet assembly
  // ----------------------------------------
  // Earliest octet lands in the top byte of each lane word
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      for (int o = 0; o < OCTETS; o++) begin
        word_asm[l*WORD_W + (OCTETS-1-o)*OCTET_W +: OCTET_W] =
          (o == OCTETS-1) ? I_OCTET[l*OCTET_W +: OCTET_W]
                          : st_reg.asm_w[o][l*OCTET_W +: OCTET_W];
      end
    end
  end

  assign word_done   = I_OCTET_VLD && (st_reg.asm_cnt == $clog2(OCTETS)'(OCTETS-1));
  // Buffer full stalls the decoders rather than losing a word
  assign O_OCTET_RDY = (st_reg.buf_n < 2'(BUF_DEPTH));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (I_OCTET_VLD && O_OCTET_RDY) begin
      st_next.asm_w[st_reg.asm_cnt] = I_OCTET;
      st_next.asm_cnt = st_reg.asm_cnt + 1'b1;
    end
    // Output stage: one word per cycle, never waits on sink_accept
    st_next.out_v = 1'b0;
    if (st_reg.buf_n != 2'h0) begin
      st_next.out_d = st_reg.buf_d[0];
      st_next.out_v = 1'b1;
      st_next.buf_d[0] = st_reg.buf_d[1];
    end
    st_next.buf_n = st_reg.buf_n - ((st_reg.buf_n != 2'h0) ? 2'h1 : 2'h0);
    if (word_done && O_OCTET_RDY) begin
      st_next.buf_d[st_next.buf_n[0]] = word_asm;
      st_next.buf_n = st_next.buf_n + 2'h1;
    end
    // Sink not ready while word goes out: flagged on O_DROP, word still sent
    st_next.drop = st_reg.out_v && !LNK.sink_accept;
    // Set wins over clear
    if (I_FAULT_CLR) begin
      st_next.fault = 1'b0;
    end
    if (LNK.transfer_fault_in) begin
      st_next.fault = 1'b1;
    end
    // Front-end reset request crosses from the reconfiguration clock
    st_next.afe_rst_s1 = afe_rst_rc;
    st_next.afe_rst_s2 = st_reg.afe_rst_s1;
    // Front-end ready after a settling count, independent of hard reset
    if (st_reg.rdy_cnt != READY_DLY) begin
      st_next.rdy_cnt = st_reg.rdy_cnt + 4'h1;
    end
    // One shared counter: any port's front-end reset restarts every lane
    if (|st_reg.afe_rst_s2) begin
      st_next.rdy_cnt = 4'h0;
    end
    st_next.afe = '0;
    if ((st_reg.rdy_cnt == READY_DLY) && !(|st_reg.afe_rst_s2)) begin
      st_next.afe = {LANES{1'b1}};
    end
    if (LNK.rx_hard_reset) begin
      st_next.asm_cnt = '0;
      st_next.buf_n   = 2'h0;
      st_next.out_v   = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign LNK.lane_word_out   = st_reg.out_d;
  assign LNK.lane_word_valid = st_reg.out_v;
  assign LNK.afe_ready       = st_reg.afe;
  assign LNK.rx_ready        = st_reg.afe & {LANES{!LNK.rx_hard_reset}};
  assign O_FAULT_STICKY      = st_reg.fault;
  assign O_DROP              = st_reg.drop;

  // ----------------------------------------
  // Reconfiguration strobes, one controller per port
  // ----------------------------------------
  // Runs on the reconfiguration clock; strobes come from that domain
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      typedef struct packed {
        jrx_hs_e    hs;
        logic [3:0] cnt;
        logic       afe_rst;
      } jrx_rc_s;
      jrx_rc_s rc_reg;
      jrx_rc_s rc_next;
      always_comb begin
        rc_next = rc_reg;
        unique case (rc_reg.hs)
          JRX_HS_IDLE: begin
            if (LNK.rcfg_write[p] || LNK.rcfg_read[p]) begin
              rc_next.hs  = JRX_HS_BUSY;
              rc_next.cnt = 4'h0;
            end
          end
          JRX_HS_BUSY: begin
            rc_next.cnt = rc_reg.cnt + 4'h1;
            if (rc_reg.cnt == 4'(RCFG_WAIT_CY - 1)) begin
              rc_next.hs = JRX_HS_DONE;
              // Only path that resets the front end
              if (LNK.rcfg_write[p]) begin
                rc_next.afe_rst = LNK.rcfg_afe_reset[p];
              end
            end
          end
          JRX_HS_DONE: rc_next.hs = JRX_HS_IDLE;
          default: rc_next.hs = JRX_HS_IDLE;
        endcase
      end
      always_ff @(posedge LNK.rcfg_clk) begin
        if (LNK.rcfg_reset[p]) begin
          rc_reg <= '0;
        end else begin
          rc_reg <= rc_next;
        end
      end
      // Held high until the access completes
      assign LNK.rcfg_waitrequest[p] = (LNK.rcfg_write[p] || LNK.rcfg_read[p])
                                       && (rc_reg.hs != JRX_HS_DONE);
      // Kept in this domain; the main clock synchronises it
      assign afe_rst_rc[p] = rc_reg.afe_rst;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== design/jrx_tl.sv ====
`timescale 1ns/10ps
`default_nettype none
module jrx_tl #(
  parameter int LANES = jrx_pkg::LANES_DEF,
  parameter int NPORT = 1
) (
  // Clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST,
  // Link
  jrx_if.tl                                  LNK,
  // User side
  input  wire logic                          I_ACCEPT,
  input  wire logic                          I_HARD_RESET,
  input  wire logic [NPORT-1:0]              I_WR,
  input  wire logic [NPORT-1:0]              I_RD,
  input  wire logic [NPORT-1:0]              I_AFE_RESET,
  output logic [LANES*jrx_pkg::WORD_W-1:0]   O_WORD,
  output logic                               O_WORD_VLD,
  output logic                               O_FAULT
);
  import jrx_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [LANES*WORD_W-1:0] word;
    logic                    vld;
    logic                    fault;
    logic                    hrst;
    logic [NPORT-1:0]        wr;
    logic [NPORT-1:0]        rd;
  } jrx_tl_s;

  jrx_tl_s st_reg;
  jrx_tl_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.word = LNK.lane_word_out;
    st_next.vld  = LNK.lane_word_valid;
    // Fault: valid word while not accepting; the word still passes to O_WORD
    st_next.fault = LNK.lane_word_valid && !I_ACCEPT;
    // Reset only changes once front end is up
    if (&LNK.afe_ready) st_next.hrst = I_HARD_RESET;
    // Strobes held until wait-request drops
    for (int p = 0; p < NPORT; p++) begin
      if (!st_reg.wr[p] && !st_reg.rd[p]) begin
        st_next.wr[p] = I_WR[p];
        st_next.rd[p] = I_RD[p] && !I_WR[p];
      end else if (!LNK.rcfg_waitrequest[p]) begin
        st_next.wr[p] = 1'b0;
        st_next.rd[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign LNK.sink_accept       = I_ACCEPT;
  assign LNK.transfer_fault_in = st_reg.fault;
  assign LNK.rx_hard_reset     = st_reg.hrst;
  assign LNK.rcfg_clk          = I_CLK;
  assign LNK.rcfg_reset        = {NPORT{I_RST}};
  assign LNK.rcfg_write        = st_reg.wr;
  assign LNK.rcfg_read         = st_reg.rd;
  assign LNK.rcfg_afe_reset    = I_AFE_RESET;
  assign O_WORD                = st_reg.word;
  assign O_WORD_VLD            = st_reg.vld;
  assign O_FAULT               = st_reg.fault;
endmodule
`default_nettype wire

// ==== verif/jrx_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module jrx_chk #(
  parameter int LANES = 2,
  parameter int NPORT = 1
) (
  input wire logic             I_CLK,
  input wire logic             I_RST,
  input wire logic             lane_word_valid,
  input wire logic             sink_accept,
  input wire logic [LANES-1:0] rx_ready,
  input wire logic [LANES-1:0] afe_ready,
  input wire logic             rx_hard_reset,
  input wire logic [NPORT-1:0] rcfg_write,
  input wire logic [NPORT-1:0] rcfg_read,
  input wire logic [NPORT-1:0] rcfg_waitrequest
);
  // ----------------------------------------
  // Link checks, port 0 only
  // ----------------------------------------
  logic rq;
  assign rq = rcfg_write[0] | rcfg_read[0];
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  AST_RDY_LANE: assert property (rx_ready == (afe_ready & ~{LANES{rx_hard_reset}}))
    else $error("rx ready not tied to front end and hard reset");
  AST_HRST_VLD: assert property (rx_hard_reset |=> !lane_word_valid)
    else $error("valid word during hard reset");
  AST_HRST_AFE: assert property (rx_hard_reset && (&afe_ready) && !rq |=> &afe_ready)
    else $error("hard reset disturbed front end");
  AST_HRST_GATE: assert property ($changed(rx_hard_reset) |-> &($past(afe_ready)))
    else $error("hard reset moved before front end ready");
  AST_WAIT_SEQ: assert property ($rose(rq) |-> rcfg_waitrequest[0] [*3] ##1 !rcfg_waitrequest[0])
    else $error("wait request length wrong");
  AST_WAIT_IDLE: assert property (!rq |-> !rcfg_waitrequest[0])
    else $error("wait request without strobe");
  AST_STB_HOLD: assert property ($fell(rq) |-> !$past(rcfg_waitrequest[0]))
    else $error("strobe dropped while wait request high");
  AST_VLD_PULSE: assert property (lane_word_valid |=> !lane_word_valid)
    else $error("valid held past one cycle");
  AST_NO_HOLD: assert property (lane_word_valid && !sink_accept |=> !lane_word_valid)
    else $error("refused word was held");
endmodule
`default_nettype wire

// ==== verif/tb_jesd_rx_link_output_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_jesd_rx_link_output_port;
  import jrx_pkg::*;
  localparam int L = LANES_DEF;
  localparam int W = L * WORD_W;
  logic               I_CLK, I_RST, vld, clr, acc, hrst, wr, rd, afe, acc_d;
  logic               rdy, sticky, drop, wvld, tfault, fexp;
  logic [L*OCTET_W-1:0] oct;
  logic [W-1:0]       word;
  logic [W-1:0]       exp_q[$];
  logic [31:0]        seed;
  int                 bad_count, num_checks;
  jrx_if #(.LANES(L), .NPORT(1)) ifc ();
  jrx_dev #(.LANES(L)) i_jrx_dev (.I_CLK(I_CLK), .I_RST(I_RST), .LNK(ifc.dev), .I_OCTET(oct),
    .I_OCTET_VLD(vld), .O_OCTET_RDY(rdy), .O_FAULT_STICKY(sticky), .I_FAULT_CLR(clr), .O_DROP(drop));
  jrx_tl #(.LANES(L), .NPORT(1)) i_jrx_tl (.I_CLK(I_CLK), .I_RST(I_RST), .LNK(ifc.tl),
    .I_ACCEPT(acc), .I_HARD_RESET(hrst), .I_WR(wr), .I_RD(rd), .I_AFE_RESET(afe),
    .O_WORD(word), .O_WORD_VLD(wvld), .O_FAULT(tfault));
  jrx_chk #(.LANES(L), .NPORT(1)) u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
    .lane_word_valid(ifc.lane_word_valid), .sink_accept(ifc.sink_accept),
    .rx_ready(ifc.rx_ready), .afe_ready(ifc.afe_ready), .rx_hard_reset(ifc.rx_hard_reset),
    .rcfg_write(ifc.rcfg_write), .rcfg_read(ifc.rcfg_read),
    .rcfg_waitrequest(ifc.rcfg_waitrequest));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [W-1:0] e, logic [W-1:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic step();
    @(posedge I_CLK);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Octets back to back; accept toggles at random since the source must not care
  task automatic send(int n);
    logic [W-1:0] w;
    logic [31:0]  t;
    for (int i = 0; i < n; i++) begin
      if (i % OCTETS == 0) begin
        for (int j = 0; j < L; j++) w[j*WORD_W +: WORD_W] = rnd();
      end
      for (int j = 0; j < L; j++) begin
        oct[j*OCTET_W +: OCTET_W] = w[j*WORD_W + WORD_W - OCTET_W*(i%OCTETS+1) +: OCTET_W];
      end
      t = rnd();
      acc = t[0];
      vld = 1'b1;
      chk("octet ready", W'(1), W'(rdy));
      step();
      if (i % OCTETS == OCTETS - 1) exp_q.push_back(w);
    end
    vld = 1'b0;
  endtask
  // Strobe held until wait request drops, released after that edge
  task automatic rcfg(logic w, logic a);
    int n;
    int k;
    n = 0;
    k = 0;
    wr = w;
    rd = !w;
    afe = a;
    do begin
      @(negedge I_CLK);
      k++;
      if (ifc.rcfg_waitrequest[0] === 1'b1) n++;
    end while (!((ifc.rcfg_write[0] | ifc.rcfg_read[0]) === 1'b1
                 && ifc.rcfg_waitrequest[0] === 1'b0) && k < 20);
    chk("wait cycles", W'(RCFG_WAIT_CY + 1), W'(n));
    chk("strobes", W'({w, !w}), W'({ifc.rcfg_write[0], ifc.rcfg_read[0]}));
    step();
    wr = 1'b0;
    rd = 1'b0;
    repeat (3) step();
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  initial begin
    #200000;
    bad_count++;
    results();
  end
  always @(negedge I_CLK) begin
    if (!I_RST && wvld === 1'b1) begin
      chk("words pending", W'(1), W'(exp_q.size() != 0));
      if (exp_q.size() != 0) chk("lane word", exp_q.pop_front(), word);
      chk("drop flag", W'(!acc_d), W'(drop));
      chk("frame fault", W'(!acc_d), W'(tfault));
      if (!acc_d) fexp = 1'b1;
    end
    acc_d = ifc.sink_accept;
  end
  initial begin
    {I_RST, acc, acc_d} = 3'h7;
    {vld, clr, hrst, wr, rd, afe} = 6'h0;
    oct = '0;
    fexp = 1'b0;
    seed = 32'h4b;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(posedge I_CLK);
    #1;
    I_RST = 1'b0;
    repeat (6) step();
    chk("front end ready", W'({L{1'b1}}), W'(ifc.afe_ready));
    send(40);
    repeat (4) step();
    // Partial word must vanish under hard reset
    send(2);
    hrst = 1'b1;
    repeat (3) step();
    chk("rx ready", W'(0), W'(ifc.rx_ready));
    chk("front end kept", W'({L{1'b1}}), W'(ifc.afe_ready));
    hrst = 1'b0;
    repeat (3) step();
    send(8);
    repeat (4) step();
    rcfg(1'b1, 1'b1);
    chk("front end reset", W'(0), W'(ifc.afe_ready));
    rcfg(1'b1, 1'b0);
    rcfg(1'b0, 1'b0);
    chk("front end back", W'({L{1'b1}}), W'(ifc.afe_ready));
    chk("fault flag", W'(fexp), W'(sticky));
    clr = 1'b1;
    step();
    clr = 1'b0;
    chk("fault cleared", W'(0), W'(sticky));
    repeat (5) step();
    chk("words left", W'(0), W'(exp_q.size()));
    results();
  end
endmodule
`default_nettype wire
